//--- design/dmcl_pkg.sv
// constants and types for the pin mapping and continuous link block
package dmcl_pkg;
	localparam int AW = 5;
	localparam int DW = 16;

	// register byte addresses
	localparam logic [4:0] SEL1_OFS   = 5'h00;
	localparam logic [4:0] SEL2_OFS   = 5'h04;
	localparam logic [4:0] CTRL_OFS   = 5'h08;
	localparam logic [4:0] BITDIV_OFS = 5'h0C;
	localparam logic [4:0] STAT_OFS   = 5'h10;
	localparam logic [4:0] MASK_OFS   = 5'h14;
	localparam logic [4:0] STATE_OFS  = 5'h18;

	// mapping code positions: pins 0..3 in select 1, pins 4..5 in select 2
	localparam int P0_POS = 6;
	localparam int P1_POS = 4;
	localparam int P2_POS = 2;
	localparam int P3_POS = 0;
	localparam int P4_POS = 6;
	localparam int P5_POS = 4;

	// control fields
	localparam int MODE_POS    = 0;
	localparam int PACKET_BIT  = 3;
	localparam int BSYNC_BIT   = 4;
	localparam int SHAPING_BIT = 5;

	// interrupt status bits
	localparam int EV_TXBIT = 0;
	localparam int EV_RXBIT = 1;
	localparam int EV_PIN0  = 2;

	// reset values
	localparam logic [7:0]  SEL_RST    = 8'h00;
	localparam logic [7:0]  CTRL_RST   = 8'h08;
	localparam logic [15:0] BITDIV_RST = 16'h0014;
	localparam logic [2:0]  IRQ_RST    = 3'h0;

	// fifo depth in bytes
	localparam logic [6:0] FIFO_BYTES = 7'h40;

	typedef enum logic [2:0] {
		DMCL_SLEEP, DMCL_STANDBY, DMCL_FS_TX, DMCL_TX, DMCL_FS_RX, DMCL_RX
	} dmcl_mode_t;
endpackage : dmcl_pkg

//--- design/dmcl_top.sv
// pin function mapping and continuous serial link
// Operation
// - six output pins 0..5, function chosen by two select registers
// - each pin has a 2-bit code; output depends on code, data and chip mode
// - continuous: pin0 match/ready codes, pin1 code 00 is bit clock
// - packet: pin0 payload/sent/crc, pin1 threshold, empty, full
// - pin5: clock out (sleep only with RC), lock, mode ready
// - continuous: NRZ passes directly over two-way pin 2, fifo idle
// - continuous transmit: device drives bit clock on pin 1
// - transmit data sampled on bit clock rising edge; host obeys window
// - receive without synchronizer: raw data on pin 2, no clock
// - receive with synchronizer: clean data pin 2, clock pin 1
// - synchronized receive: data changes on falling clock edge
// - packet mode: no bits on pins, data through the fifo
// - packet mode: handler does preamble, sync, crc, whitening, coding
// - fifo access allowed in sleep or standby in packet mode; here allowed in any mode once packet mode is chosen
// - synchronizer forced on in packet mode
// - fifo empty and full flags from the whole fifo level
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
module dmcl_top
	import dmcl_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          sys_rst,
	input  wire logic [AW-1:0] reg_addr,
	input  wire logic [DW-1:0] reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [DW-1:0] reg_rdata,
	output logic               irq,
	input  wire logic          pattern_match,
	input  wire logic          transmit_ready,
	input  wire logic          receive_ready,
	input  wire logic          rssi_or_preamble,
	input  wire logic          payload_ready_a,
	input  wire logic          packet_sent_b,
	input  wire logic          crc_good,
	input  wire logic          fifo_threshold,
	input  wire logic [6:0]    fifo_count,
	input  wire logic          clock_output,
	input  wire logic          rc_running,
	input  wire logic          synthesizer_locked,
	input  wire logic          mode_ready_e,
	input  wire logic          temperature_changed,
	input  wire logic          battery_low,
	input  wire logic          rx_timeout,
	input  wire logic          demod_bit,
	output logic               mod_bit,
	output logic               mod_bit_strobe,
	output logic [5:0]         gpio_out,
	input  wire logic          serial_bit_in,
	output logic               serial_bit_oe_n,
	output logic               bit_clock_pin,
	output logic               bitsync_active,
	output logic               packet_handler_en,
	output logic               fifo_access_ok,
	output logic               fifo_empty_c,
	output logic               fifo_full_d
);
	logic [7:0]  sel1_q;
	logic [7:0]  sel2_q;
	logic [7:0]  ctrl_q;
	logic [15:0] bitdiv_q;
	logic [2:0]  stat_q;
	logic [2:0]  mask_q;
	logic [DW-1:0] rdata_q;
	logic [15:0] div_cnt_q;
	logic        dclk_q;
	logic        ser_m_q;
	logic        ser_s_q;
	logic        mod_bit_q;
	logic        mod_stb_q;
	logic        rx_data_q;
	logic        rx_stb_q;
	logic        pin0_prev_q;
	logic [5:0]  pins_q;
	logic [5:0]  pins_d;
	logic        ser_oe_n_q;
	logic        ser_oe_n_d;
	dmcl_mode_t  mode;
	logic        packet;
	logic        bsync_on;
	logic        in_rx;
	logic        in_tx;
	logic        clk_run;
	logic        dclk_rise;
	logic        dclk_fall;
	logic        serial_out;
	logic [2:0]  ev;

	// picks a pin's 2-bit mapping code out of a select register
	function automatic logic [1:0] code_of(input logic [7:0] sel,
		input int pos);
		code_of = sel[pos +: 2];
	endfunction : code_of

	// true in the modes where the synthesizer runs or data moves
	function automatic logic synth_up(input dmcl_mode_t m);
		synth_up = (m != DMCL_SLEEP) && (m != DMCL_STANDBY);
	endfunction : synth_up

	// chip mode decode; unused codes fall back to standby
	always_comb begin
		unique case (ctrl_q[MODE_POS +: 3])
			3'h0: mode = DMCL_SLEEP;
			3'h1: mode = DMCL_STANDBY;
			3'h2: mode = DMCL_FS_TX;
			3'h3: mode = DMCL_TX;
			3'h4: mode = DMCL_FS_RX;
			3'h5: mode = DMCL_RX;
			default: mode = DMCL_STANDBY;
		endcase
	end

	assign packet   = ctrl_q[PACKET_BIT];
	assign bsync_on = packet | ctrl_q[BSYNC_BIT];
	assign in_rx    = (mode == DMCL_RX);
	assign in_tx    = (mode == DMCL_TX);
	// clock runs in continuous transmit, and in continuous receive only with the synchronizer
	assign clk_run  = !packet && (in_tx || (in_rx && bsync_on));
	assign fifo_empty_c = (fifo_count == 7'h00);
	assign fifo_full_d  = (fifo_count >= FIFO_BYTES);
	assign bitsync_active    = bsync_on;
	assign packet_handler_en = packet;
	// fifo reachable in any mode once packet mode is chosen
	assign fifo_access_ok    = packet;

	// register writes
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sel1_q   <= SEL_RST;
			sel2_q   <= SEL_RST;
			ctrl_q   <= CTRL_RST;
			bitdiv_q <= BITDIV_RST;
			mask_q   <= IRQ_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				SEL1_OFS:   sel1_q   <= reg_wdata[7:0];
				SEL2_OFS:   sel2_q   <= reg_wdata[7:0];
				CTRL_OFS:   ctrl_q   <= reg_wdata[7:0];
				BITDIV_OFS: bitdiv_q <= reg_wdata;
				MASK_OFS:   mask_q   <= reg_wdata[2:0];
				default:    ;
			endcase
		end
	end

	// sticky events; a new event beats a write-one clear
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_q <= IRQ_RST;
		end else begin
			stat_q <= (stat_q & ~((reg_wr && reg_addr == STAT_OFS)
				? reg_wdata[2:0] : 3'h0)) | ev;
		end
	end

	always_comb begin
		ev = 3'h0;
		ev[EV_TXBIT] = mod_stb_q;
		ev[EV_RXBIT] = rx_stb_q;
		ev[EV_PIN0]  = pins_q[0] & ~pin0_prev_q;
	end

	assign irq = |(stat_q & mask_q);

	// read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				SEL1_OFS:   rdata_q <= {8'h00, sel1_q};
				SEL2_OFS:   rdata_q <= {8'h00, sel2_q};
				CTRL_OFS:   rdata_q <= {8'h00, ctrl_q};
				BITDIV_OFS: rdata_q <= bitdiv_q;
				STAT_OFS:   rdata_q <= {13'h0000, stat_q};
				MASK_OFS:   rdata_q <= {13'h0000, mask_q};
				STATE_OFS:  rdata_q <= {6'h00, bsync_on, dclk_q,
					ser_oe_n_q, mod_bit_q, pins_q};
				default:    rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign reg_rdata = rdata_q;

	// bit clock divider: half period is bitdiv_q cycles, minimum one
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt_q <= 16'h0000;
			dclk_q    <= 1'b0;
		end else if (!clk_run) begin
			div_cnt_q <= 16'h0000;
			dclk_q    <= 1'b0;
		end else if (div_cnt_q + 16'h0001 >= bitdiv_q) begin
			div_cnt_q <= 16'h0000;
			dclk_q    <= ~dclk_q;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
		end
	end

	assign dclk_rise = clk_run && !dclk_q && (div_cnt_q + 16'h0001 >= bitdiv_q);
	assign dclk_fall = clk_run && dclk_q && (div_cnt_q + 16'h0001 >= bitdiv_q);

	// host data from the two-way pin passes two flops first
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ser_m_q <= 1'b0;
			ser_s_q <= 1'b0;
		end else begin
			ser_m_q <= serial_bit_in;
			ser_s_q <= ser_m_q;
		end
	end

	// transmit: take host data on the clock's rising edge
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mod_bit_q <= 1'b0;
			mod_stb_q <= 1'b0;
		end else begin
			mod_stb_q <= 1'b0;
			if (in_tx && !packet && dclk_rise) begin
				mod_bit_q <= ser_s_q;
				mod_stb_q <= 1'b1;
			end
		end
	end

	assign mod_bit        = mod_bit_q;
	assign mod_bit_strobe = mod_stb_q;

	// receive: raw follow without sync, else update on falling edge
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_data_q <= 1'b0;
			rx_stb_q  <= 1'b0;
		end else begin
			rx_stb_q <= 1'b0;
			if (in_rx && !bsync_on) begin
				rx_data_q <= demod_bit;
			end else if (in_rx && dclk_fall) begin
				rx_data_q <= demod_bit;
				rx_stb_q  <= 1'b1;
			end
		end
	end

	// pin 2 direction: driven except in continuous transmit
	always_comb begin
		ser_oe_n_d = 1'b0;
		serial_out = 1'b0;
		if (!packet) begin
			if (in_rx) begin
				serial_out = rx_data_q;
			end else begin
				ser_oe_n_d = in_tx;
			end
		end
	end

	// function mapping per pin; anything unlisted drives low
	always_comb begin
		pins_d = 6'h00;
		// pin 0
		unique case (code_of(sel1_q, P0_POS))
			2'b00: begin
				if (packet) begin
					pins_d[0] = in_rx ? payload_ready_a
						: (in_tx & packet_sent_b);
				end else begin
					pins_d[0] = in_rx ? pattern_match
						: (in_tx & transmit_ready);
				end
			end
			2'b01: begin
				if (packet) begin
					pins_d[0] = in_rx & crc_good;
				end else begin
					pins_d[0] = (mode == DMCL_FS_TX || mode == DMCL_FS_RX)
						& rssi_or_preamble;
				end
			end
			2'b10: begin
				if (!packet) begin
					pins_d[0] = in_rx ? receive_ready
						: (in_tx & transmit_ready);
				end
			end
			2'b11: begin
				if (packet) begin
					pins_d[0] = synth_up(mode) &
						(temperature_changed | battery_low);
				end
			end
		endcase
		// pin 1
		unique case (code_of(sel1_q, P1_POS))
			2'b00: pins_d[1] = packet ? fifo_threshold : dclk_q;
			2'b01: pins_d[1] = packet ? fifo_empty_c
				: (in_rx & rssi_or_preamble);
			2'b10: pins_d[1] = packet & fifo_full_d;
			2'b11: pins_d[1] = 1'b0;
		endcase
		// pin 2: data in continuous, status in packet
		if (!packet) begin
			pins_d[2] = serial_out;
		end else begin
			unique case (code_of(sel1_q, P2_POS))
				2'b00: pins_d[2] = fifo_full_d;
				2'b01: pins_d[2] = in_rx & receive_ready;
				2'b10: pins_d[2] = in_rx ? rx_timeout : fifo_full_d;
				2'b11: pins_d[2] = in_rx ? pattern_match : fifo_full_d;
			endcase
		end
		// pin 3
		unique case (code_of(sel1_q, P3_POS))
			2'b00: pins_d[3] = packet ? fifo_empty_c : (in_rx & rx_timeout);
			2'b01: pins_d[3] = packet ? (in_tx & transmit_ready)
				: (in_rx & rssi_or_preamble);
			2'b10: pins_d[3] = packet & fifo_empty_c;
			2'b11: pins_d[3] = packet ? fifo_empty_c
				: (mode != DMCL_SLEEP) & (temperature_changed | battery_low);
		endcase
		// pin 4
		unique case (code_of(sel2_q, P4_POS))
			2'b00: pins_d[4] = synth_up(mode) &
				(temperature_changed | battery_low);
			2'b01: pins_d[4] = synth_up(mode) & synthesizer_locked;
			2'b10: pins_d[4] = in_rx & rx_timeout;
			2'b11: pins_d[4] = packet ? (in_rx & rssi_or_preamble)
				: ((mode != DMCL_SLEEP) & mode_ready_e);
		endcase
		// pin 5
		unique case (code_of(sel2_q, P5_POS))
			2'b00: pins_d[5] = clock_output &
				((mode != DMCL_SLEEP) | rc_running);
			2'b01: pins_d[5] = synth_up(mode) & synthesizer_locked;
			2'b10: pins_d[5] = !packet & in_rx & rssi_or_preamble;
			2'b11: pins_d[5] = (mode != DMCL_SLEEP) & mode_ready_e;
		endcase
	end

	// pin outputs come from flops
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pins_q      <= 6'h00;
			ser_oe_n_q  <= 1'b1;
			pin0_prev_q <= 1'b0;
		end else begin
			pins_q      <= pins_d;
			ser_oe_n_q  <= packet ? 1'b0 : ser_oe_n_d;
			pin0_prev_q <= pins_q[0];
		end
	end

	assign gpio_out        = pins_q;
	assign serial_bit_oe_n = ser_oe_n_q;
	assign bit_clock_pin   = pins_q[1];
endmodule : dmcl_top

//--- bench/dmcl_chk_sva.sv
// port assertions for the pin mapping and serial link block
`timescale 1ns/10ps
module dmcl_chk
	import dmcl_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic       reg_wr,
	input wire logic [6:0] fifo_count,
	input wire logic       fifo_empty_c,
	input wire logic       fifo_full_d,
	input wire logic       packet_handler_en,
	input wire logic       bitsync_active,
	input wire logic       fifo_access_ok,
	input wire logic       mod_bit,
	input wire logic       mod_bit_strobe,
	input wire logic [5:0] gpio_out,
	input wire logic       serial_bit_oe_n,
	input wire logic       bit_clock_pin
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// fifo level flags and packet mode levels
	AST_EMPTY: assert property (fifo_empty_c == (fifo_count == 7'h00))
		else $error("empty flag wrong");
	AST_FULL: assert property (fifo_full_d == (fifo_count >= 7'h40))
		else $error("full flag wrong");
	AST_BSYNC: assert property (packet_handler_en |-> bitsync_active)
		else $error("synchronizer off in packet mode");
	AST_FIFO: assert property (fifo_access_ok == packet_handler_en)
		else $error("fifo access flag wrong");
	AST_NOBIT: assert property (packet_handler_en[*3] |->
		!mod_bit_strobe) else $error("bit taken in packet mode");
	// transmit bit capture against the bit clock
	// pin 1 shows the internal clock one cycle after the capture edge
	AST_TXCLK: assert property (mod_bit_strobe |->
		serial_bit_oe_n ##1 bit_clock_pin) else $error("strobe off clock");
	AST_PULSE: assert property (mod_bit_strobe |=> !mod_bit_strobe)
		else $error("strobe too long");
	AST_LATCH: assert property (serial_bit_oe_n && $changed(mod_bit) |->
		##[0:1] mod_bit_strobe) else $error("bit without strobe");
	// synchronized receive data moves only with a falling clock
	AST_RXEDGE: assert property (!packet_handler_en && bitsync_active &&
		!serial_bit_oe_n && $changed(gpio_out[2]) && !$past(reg_wr) &&
		!$past(reg_wr, 2) && !$past(reg_wr, 3) |-> $fell(bit_clock_pin))
		else $error("data moved off falling edge");
	// main scenarios reached
	cover property (mod_bit_strobe);
	cover property (fifo_full_d);
	cover property (bitsync_active && !packet_handler_en && $fell(bit_clock_pin));
endmodule : dmcl_chk

//--- bench/dmcl_host.sv
// host side of the continuous serial link
`timescale 1ns/10ps
module dmcl_host (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       dclk,
	input  wire logic       pin_out,
	input  wire logic       oe_n,
	output logic            line,
	output logic            tx_bit,
	output logic            rx_bit,
	output logic [7:0]      rises
);
	logic       dclk_q;
	logic [7:0] pat_q;
	// resolved data pin: host drives only once the device lets go
	assign line = oe_n ? tx_bit : pin_out;
	assign tx_bit = pat_q[7];
	// sample on rising clock, move own data on falling clock
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dclk_q <= 1'b0;
			pat_q <= 8'hB4;
			rx_bit <= 1'b0;
			rises <= 8'h00;
		end else begin
			dclk_q <= dclk;
			if (dclk && !dclk_q) begin
				rx_bit <= line;
				rises <= rises + 8'h01;
			end
			if (!dclk && dclk_q)
				pat_q <= {pat_q[6:0], pat_q[7]};
		end
	end
endmodule : dmcl_host

//--- bench/dmcl_top_test.sv
// self-checking bench for the pin mapping and serial link
`timescale 1ns/10ps
module dmcl_top_test
	import dmcl_pkg::*;
;
	logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [AW-1:0] reg_addr = '0;
	logic [DW-1:0] reg_wdata = '0, reg_rdata;
	logic [15:0]   src = '0;
	logic [6:0]    fifo_count = 7'h05;
	logic demod_bit = 1'b0, irq, mod_bit, mod_bit_strobe, serial_bit_in;
	logic serial_bit_oe_n, bit_clock_pin, bitsync_active, fifo_access_ok;
	logic packet_handler_en, fifo_empty_c, fifo_full_d, tx_bit, rx_bit;
	logic [5:0]    gpio_out;
	logic [7:0]    rises, r0;
	int failures = 0, comparisons = 0, n;
	wire pattern_match = src[0], transmit_ready = src[1];
	wire receive_ready = src[2], rssi_or_preamble = src[3];
	wire payload_ready_a = src[4], packet_sent_b = src[5], crc_good = src[6];
	wire fifo_threshold = src[7], clock_output = src[8], rc_running = src[9];
	wire synthesizer_locked = src[10], mode_ready_e = src[11];
	wire temperature_changed = src[12], battery_low = src[13];
	wire rx_timeout = src[14];
	// ctrl, sel1, sel2, pin, source index (F: none), always-on sources
	localparam logic [47:0] TBL [0:15] = '{
		48'h05_00_00_00_0000, 48'h03_00_00_01_0000,
		48'h04_40_00_03_0000, 48'h02_40_00_03_0000,
		48'h05_80_00_02_0000, 48'h03_80_00_01_0000,
		48'h00_00_00_0F_7FFF, 48'h0D_00_00_04_0000,
		48'h0B_00_00_05_0000, 48'h0D_40_00_06_0000,
		48'h0D_00_00_17_0000, 48'h09_00_00_58_0000,
		48'h08_00_00_58_0200, 48'h08_00_00_5F_0100,
		48'h0D_00_10_5A_0000, 48'h09_00_30_5B_0000};
	dmcl_top u_dut (.*);
	dmcl_host u_host (.ref_clk, .rst(sys_rst), .dclk(bit_clock_pin),
		.pin_out(gpio_out[2]), .oe_n(serial_bit_oe_n), .line(serial_bit_in),
		.tx_bit, .rx_bit, .rises);
	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : cyc
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk(reg_rdata, e);
	endtask : rd
	task automatic map_case(input logic [47:0] e);
		wr(CTRL_OFS, {8'h00, e[47:40]});
		wr(SEL1_OFS, {8'h00, e[39:32]});
		wr(SEL2_OFS, {8'h00, e[31:24]});
		src <= e[15:0];
		cyc(3);
		@(negedge ref_clk);
		chk(16'(gpio_out[e[23:20]]), 16'h0000);
		@(posedge ref_clk);
		src <= e[15:0] | (16'h0001 << e[19:16]);
		cyc(3);
		@(negedge ref_clk);
		chk(16'(gpio_out[e[23:20]]), 16'(e[19:16] != 4'hF));
	endtask : map_case
	task automatic fcase(input logic [7:0] s, input logic [6:0] c,
		input logic [2:0] e);
		wr(SEL1_OFS, {8'h00, s});
		fifo_count <= c;
		cyc(2);
		@(negedge ref_clk);
		chk({13'h0000, gpio_out[1], fifo_empty_c, fifo_full_d}, {13'h0000, e});
	endtask : fcase
	task automatic complete_run;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	// main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(CTRL_OFS, {8'h00, CTRL_RST});
		rd(BITDIV_OFS, BITDIV_RST);
		rd(5'h1C, 16'h0000);
		chk({14'h0000, bitsync_active, fifo_access_ok}, 16'h0003);
		$display("reset test done");
		for (int i = 0; i < 16; i++)
			map_case(TBL[i]);
		$display("mapping test done");
		fcase(8'h10, 7'h00, 3'b110);
		fcase(8'h10, 7'h01, 3'b000);
		fcase(8'h20, 7'h40, 3'b101);
		fcase(8'h20, 7'h3F, 3'b000);
		$display("fifo test done");
		wr(SEL1_OFS, 16'h0000);
		wr(CTRL_OFS, 16'h0005);
		r0 = rises;
		demod_bit <= 1'b1;
		cyc(4);
		@(negedge ref_clk);
		chk(16'({bitsync_active, packet_handler_en,
			fifo_access_ok}), 16'h0000);
		chk(16'({gpio_out[2], serial_bit_oe_n}), 16'h0002);
		@(posedge ref_clk);
		demod_bit <= 1'b0;
		cyc(4);
		@(negedge ref_clk);
		chk(16'({gpio_out[2], 8'(rises - r0)}), 16'h0000);
		wr(BITDIV_OFS, 16'h0004);
		wr(CTRL_OFS, 16'h0015);
		demod_bit <= 1'b1;
		r0 = rises;
		cyc(40);
		@(negedge ref_clk);
		chk(16'({rx_bit, rises - r0 >= 8'h04}), 16'h0003);
		@(posedge ref_clk);
		demod_bit <= 1'b0;
		cyc(40);
		@(negedge ref_clk);
		chk(16'(rx_bit), 16'h0000);
		$display("receive test done");
		wr(BITDIV_OFS, 16'h0008);
		wr(CTRL_OFS, 16'h0003);
		wr(STAT_OFS, 16'h0007);
		wr(MASK_OFS, 16'h0001);
		for (int i = 0; i < 8; i++) begin
			n = 0;
			@(negedge ref_clk);
			while (mod_bit_strobe !== 1'b1 && n < 60) begin
				n++;
				@(negedge ref_clk);
			end
			// host holds its bit from one falling clock to the next
			chk(16'({mod_bit_strobe, mod_bit, serial_bit_oe_n}),
				16'({1'b1, tx_bit, 1'b1}));
		end
		$display("transmit test done");
		rd(STAT_OFS, 16'h0001);
		chk(16'(irq), 16'h0001);
		wr(MASK_OFS, 16'h0000);
		@(negedge ref_clk);
		chk(16'(irq), 16'h0000);
		wr(CTRL_OFS, 16'h0009);
		wr(STAT_OFS, 16'h0001);
		wr(MASK_OFS, 16'h0001);
		rd(STAT_OFS, 16'h0000);
		chk(16'(irq), 16'h0000);
		$display("interrupt test done");
		complete_run();
	end
	// watchdog against a hung wait
	initial begin
		#(20000 * 25);
		failures++;
		complete_run();
	end
endmodule : dmcl_top_test
bind dmcl_top dmcl_chk u_chk (.*);
